// ### hpp_pkg.sv
// Overview of operation
// RULE1 - Host reads data when not full: read error
// RULE2 - Host writes data when not empty: write error
// RULE3 - Core stores data while full: store error
// RULE4 - Core loads data while not empty: load error
// RULE5 - Error flags sticky, cleared only by core zero
// RULE6 - Full flag: core store sets, host read clears
// RULE7 - Empty flag: core load sets, host write clears
// RULE8 - Address lines pick data or status register
// RULE9 - Byte line picks byte in narrow mode
// RULE10 - Host never overlaps strobes or writes status
// RULE11 - Store drives read ready low unless masked
// RULE12 - Host polls full flag or read ready
// RULE13 - Host reads low byte then high byte
// RULE14 - High byte access completes narrow transfer
// RULE15 - Completed read: clear full, release, interrupt
// RULE16 - Interrupt follows its enable and global gate
// RULE17 - Write ready released at completing write fall
// RULE18 - Read ready released at completing read fall
// RULE19 - Data pins float when deselected; width select
// RULE20 - Completed write: clear empty, release, interrupt
// RULE21 - Host pins synchronised before touching flags
package hpp_pkg;
    localparam logic [15:0] ADDR_TRANSFER = 16'h3820;
    localparam logic [15:0] ADDR_STATUS = 16'h3821;
    localparam logic [15:0] STATUS_RESET = 16'h0301;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SYNC_STAGES = 2;
    localparam int BUF_DEPTH = 2;
    // Control field bits 11..6, error bits 5..2
    localparam int CTL_LSB = 6;
    localparam int CTL_W = 6;
    localparam int ERR_LSB = 2;
    localparam int ERR_W = 4;
    localparam int BIT_FULL = 1;
    localparam int BIT_EMPTY = 0;
    // Positions inside the control field
    localparam int CTL_WIDTH = 5;
    localparam int CTL_RD_MASK = 3;
    localparam int CTL_WR_MASK = 2;
    // Positions inside the error field
    localparam int ERR_RD = 3;
    localparam int ERR_WR = 2;
    localparam int ERR_ST = 1;
    localparam int ERR_LD = 0;

    typedef struct packed {
        logic sel_n;
        logic rd_n;
        logic wr_n;
        logic reg_sel;
        logic byte_sel;
        logic [15:0] data;
    } host_in_s;

    localparam int HOST_IN_W = $bits(host_in_s);
    localparam host_in_s HOST_IN_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000};
endpackage

// ### pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ### two_entry_buffer.sv
`timescale 1ns/1ns
module two_entry_buffer #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = count != FULL_COUNT;
    assign out_valid = count != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rp];

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk) begin
            if (ce && push && wp == AW'(i)) begin
                mem[i] <= in_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else if (ce) begin
            if (push) begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_no_overfill: assert property (@(posedge clk) disable iff (!rst_n)
        count <= FULL_COUNT) else $error("buffer count beyond depth");
    a_stall_holds: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled word lost or changed");
endmodule

// ### dsp_host_parallel_port.sv
`timescale 1ns/1ns
module dsp_host_parallel_port #(
    parameter int DEPTH = hpp_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] core_addr,
    input wire logic core_store,
    input wire logic core_load,
    input wire logic [15:0] core_wdata,
    output logic [15:0] core_rdata,
    input wire logic port_select_n,
    input wire logic port_read_strobe_n,
    input wire logic port_write_strobe_n,
    input wire logic register_select_line,
    input wire logic byte_select_line,
    input wire logic [15:0] port_data_in,
    output logic [15:0] port_data_out,
    output logic [15:0] port_data_oe,
    output logic read_ready_pin_n,
    output logic write_ready_pin_n,
    input wire logic out_int_enable,
    input wire logic in_int_enable,
    input wire logic global_interrupt_gate,
    input wire logic out_int_ack,
    input wire logic in_int_ack,
    output logic outbound_done_interrupt,
    output logic inbound_done_interrupt
);
    localparam int DW = hpp_pkg::DATA_W;
    localparam int BW = hpp_pkg::BYTE_W;

    hpp_pkg::host_in_s hs;
    hpp_pkg::host_in_s hp;
    logic [hpp_pkg::CTL_W-1:0] ctl;
    logic [hpp_pkg::ERR_W-1:0] err;
    logic [hpp_pkg::ERR_W-1:0] next_err;
    logic outbound_full_flag;
    logic inbound_empty_flag;
    logic next_full;
    logic next_empty;
    logic wr_hold;
    logic next_wr_hold;
    logic [DW-1:0] out_data;
    logic [BW-1:0] in_lo;
    logic [DW-1:0] in_word;
    logic [DW-1:0] status_word;
    logic [DW-1:0] rd_val;
    logic hold_full;
    logic [DW-1:0] hold_data;
    logic out_pend;
    logic in_pend;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [DW-1:0] buf_out_data;
    logic wide;
    logic st_xfer;
    logic st_stat;
    logic ld_xfer;
    logic ld_stat;
    logic rd_fall;
    logic wr_fall;
    logic wr_rise;
    logic xfer_rd;
    logic cmp_rd;
    logic xfer_wr_fall;
    logic cmp_wr_fall;
    logic cmp_wr_rise;
    logic push;
    logic pop;

    // ----------------------------------------
    // Host pin synchronisation
    // ----------------------------------------
    pin_sync #(
        .W(hpp_pkg::HOST_IN_W),
        .RST_VAL(hpp_pkg::HOST_IN_IDLE)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d({port_select_n, port_read_strobe_n, port_write_strobe_n,
            register_select_line, byte_select_line, port_data_in}), // [RULE21]
        .q(hs)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hp <= hpp_pkg::HOST_IN_IDLE;
        end else if (ce) begin
            hp <= hs;
        end
    end

    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    assign wide = ctl[hpp_pkg::CTL_WIDTH]; // [RULE19]
    assign st_xfer = core_store && core_addr == hpp_pkg::ADDR_TRANSFER;
    assign st_stat = core_store && core_addr == hpp_pkg::ADDR_STATUS;
    assign ld_xfer = core_load && core_addr == hpp_pkg::ADDR_TRANSFER;
    assign ld_stat = core_load && core_addr == hpp_pkg::ADDR_STATUS;
    // Overlapping strobes are ignored as reserved [RULE10]
    assign rd_fall = !hs.sel_n && !hs.rd_n && hp.rd_n && hs.wr_n;
    assign wr_fall = !hs.sel_n && !hs.wr_n && hp.wr_n && hs.rd_n;
    assign wr_rise = !hp.sel_n && !hp.wr_n && hp.rd_n && hs.wr_n;
    assign xfer_rd = rd_fall && !hs.reg_sel; // [RULE8]
    assign cmp_rd = xfer_rd && (wide || hs.byte_sel); // [RULE14] [RULE13]
    // Write with register line high is reserved and ignored [RULE8] [RULE10]
    assign xfer_wr_fall = wr_fall && !hs.reg_sel;
    assign cmp_wr_fall = xfer_wr_fall && (wide || hs.byte_sel); // [RULE14]
    assign cmp_wr_rise = wr_rise && !hp.reg_sel && (wide || hp.byte_sel);

    // ----------------------------------------
    // Inbound path
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_lo <= 8'h00;
        end else if (ce && wr_rise && !hp.reg_sel && !wide && !hp.byte_sel) begin
            in_lo <= hp.data[BW-1:0]; // [RULE9]
        end
    end

    assign in_word = wide ? hp.data : {hp.data[BW-1:0], in_lo}; // [RULE9]
    assign push = cmp_wr_rise && buf_in_ready;
    assign pop = buf_out_valid && !hold_full;

    two_entry_buffer #(
        .W(DW),
        .DEPTH(DEPTH)
    ) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(cmp_wr_rise),
        .in_ready(buf_in_ready),
        .in_data(in_word),
        .out_valid(buf_out_valid),
        .out_ready(!hold_full),
        .out_data(buf_out_data)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_full <= 1'b0;
            hold_data <= 16'h0000;
        end else if (ce) begin
            if (pop) begin
                hold_full <= 1'b1;
                hold_data <= buf_out_data;
            end else if (ld_xfer) begin
                hold_full <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Flags and status
    // ----------------------------------------
    always_comb begin
        next_full = outbound_full_flag;
        if (st_xfer) begin
            next_full = 1'b1; // [RULE6] [RULE11]
        end else if (cmp_rd) begin
            next_full = 1'b0; // [RULE6] [RULE15]
        end
        next_empty = inbound_empty_flag;
        if (ld_xfer) begin
            next_empty = 1'b1; // [RULE7]
        end else if (push) begin
            next_empty = 1'b0; // [RULE7] [RULE20]
        end
        next_wr_hold = wr_hold;
        if (cmp_wr_fall) begin
            next_wr_hold = 1'b1;
        end else if (wr_rise) begin
            next_wr_hold = 1'b0;
        end
        // Zero stores clear; a new event in the same cycle wins [RULE5]
        next_err = st_stat ? (err & core_wdata[hpp_pkg::ERR_LSB +: hpp_pkg::ERR_W]) : err;
        next_err[hpp_pkg::ERR_RD] = next_err[hpp_pkg::ERR_RD]
            | (xfer_rd && !outbound_full_flag); // [RULE1]
        next_err[hpp_pkg::ERR_WR] = next_err[hpp_pkg::ERR_WR]
            | (xfer_wr_fall && !inbound_empty_flag)
            | (cmp_wr_rise && !buf_in_ready); // [RULE2]
        next_err[hpp_pkg::ERR_ST] = next_err[hpp_pkg::ERR_ST]
            | (st_xfer && outbound_full_flag); // [RULE3]
        next_err[hpp_pkg::ERR_LD] = next_err[hpp_pkg::ERR_LD]
            | (ld_xfer && !inbound_empty_flag); // [RULE4]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl <= hpp_pkg::STATUS_RESET[hpp_pkg::CTL_LSB +: hpp_pkg::CTL_W];
            err <= '0;
            outbound_full_flag <= hpp_pkg::STATUS_RESET[hpp_pkg::BIT_FULL];
            inbound_empty_flag <= hpp_pkg::STATUS_RESET[hpp_pkg::BIT_EMPTY];
            wr_hold <= 1'b0;
        end else if (ce) begin
            if (st_stat) begin
                ctl <= core_wdata[hpp_pkg::CTL_LSB +: hpp_pkg::CTL_W];
            end
            err <= next_err; // [RULE5]
            outbound_full_flag <= next_full;
            inbound_empty_flag <= next_empty;
            wr_hold <= next_wr_hold;
        end
    end

    assign status_word = {4'h0, ctl, err, outbound_full_flag, inbound_empty_flag};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_data <= 16'h0000;
            core_rdata <= 16'h0000;
        end else if (ce) begin
            if (st_xfer) begin
                out_data <= core_wdata;
            end
            if (ld_xfer) begin
                core_rdata <= hold_data;
            end else if (ld_stat) begin
                core_rdata <= status_word;
            end else if (core_load) begin
                core_rdata <= 16'h0000;
            end
        end
    end

    // ----------------------------------------
    // Host data pins and ready pins
    // ----------------------------------------
    assign rd_val = hs.reg_sel ? status_word : out_data; // [RULE8]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_data_out <= 16'h0000;
            port_data_oe <= 16'h0000;
            read_ready_pin_n <= 1'b1;
            write_ready_pin_n <= 1'b1;
        end else if (ce) begin
            if (rd_fall) begin
                if (wide) begin
                    port_data_out <= rd_val;
                end else begin
                    port_data_out <= hs.byte_sel ? {8'h00, rd_val[DW-1:BW]}
                                                 : {8'h00, rd_val[BW-1:0]}; // [RULE9]
                end
            end
            if (hs.sel_n || hs.rd_n || !hs.wr_n) begin
                port_data_oe <= 16'h0000; // [RULE19]
            end else begin
                port_data_oe <= wide ? 16'hFFFF : 16'h00FF;
            end
            read_ready_pin_n <= !(next_full && !ctl[hpp_pkg::CTL_RD_MASK]); // [RULE11] [RULE18]
            write_ready_pin_n <= !(next_empty && !next_wr_hold
                && !ctl[hpp_pkg::CTL_WR_MASK]); // [RULE17]
        end
    end

    // ----------------------------------------
    // Done interrupts
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_pend <= 1'b0;
            in_pend <= 1'b0;
        end else if (ce) begin
            out_pend <= cmp_rd || (out_pend && !out_int_ack); // [RULE15]
            in_pend <= push || (in_pend && !in_int_ack); // [RULE20]
        end
    end

    // Held pending while disabled or gated [RULE16]
    assign outbound_done_interrupt = out_pend && out_int_enable && !global_interrupt_gate;
    assign inbound_done_interrupt = in_pend && in_int_enable && !global_interrupt_gate;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_read_err_set: assert property ( // [RULE1]
        ce && xfer_rd && !outbound_full_flag |=> err[hpp_pkg::ERR_RD])
        else $error("read error not set");
    a_write_err_set: assert property ( // [RULE2]
        ce && xfer_wr_fall && !inbound_empty_flag |=> err[hpp_pkg::ERR_WR])
        else $error("write error not set");
    a_store_err_set: assert property ( // [RULE3]
        ce && st_xfer && outbound_full_flag |=> err[hpp_pkg::ERR_ST])
        else $error("store error not set");
    a_load_err_set: assert property ( // [RULE4]
        ce && ld_xfer && !inbound_empty_flag |=> err[hpp_pkg::ERR_LD])
        else $error("load error not set");
    a_err_sticky: assert property ( // [RULE5]
        !st_stat |=> err >= ($past(err) & err) && (err & $past(err)) == $past(err))
        else $error("error flag lost");
    a_full_track: assert property ( // [RULE6]
        ce && st_xfer |=> outbound_full_flag ##1 (outbound_full_flag || $past(cmp_rd)))
        else $error("full flag wrong");
    a_empty_set: assert property ( // [RULE7]
        ce && ld_xfer |=> inbound_empty_flag)
        else $error("empty flag not set");
    a_read_done: assert property ( // [RULE15]
        ce && cmp_rd && !st_xfer |=> !outbound_full_flag && read_ready_pin_n && out_pend)
        else $error("read completion wrong");
    a_rd_pin_low: assert property ( // [RULE11]
        ce && st_xfer && !st_stat && !ctl[hpp_pkg::CTL_RD_MASK] |=> !read_ready_pin_n)
        else $error("read ready not driven");
    a_oe_deselect: assert property ( // [RULE19]
        ce && hs.sel_n |=> port_data_oe == 16'h0000)
        else $error("data pins driven while deselected");
    a_wr_pin_release: assert property ( // [RULE17]
        ce && cmp_wr_fall |=> write_ready_pin_n)
        else $error("write ready not released");
    a_write_done: assert property ( // [RULE20]
        ce && push && !ld_xfer |=> !inbound_empty_flag && in_pend)
        else $error("write completion wrong");

    c_wide_read: cover property (ce && cmp_rd && wide);
    c_narrow_write: cover property (ce && push && !wide);
    c_buffer_full: cover property (!buf_in_ready);
    c_store_overrun: cover property (ce && st_xfer && outbound_full_flag);
endmodule

// ### host_cpu_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// External host on the parallel port
// ----------------------------------------
module host_cpu_model (
    input wire logic clk,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    output logic sel_n,
    output logic rd_n,
    output logic wr_n,
    output logic reg_sel,
    output logic byte_sel,
    output logic [15:0] data_in
);
    logic [15:0] wire_val;

    // Pin level: device where enabled, otherwise the drifting host value
    assign wire_val = (data_oe & data_out) | (~data_oe & data_in);

    initial begin
        sel_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        reg_sel = 1'b0;
        byte_sel = 1'b0;
        data_in = 16'h5A5A;
    end

    // One strobe per access, address held across it
    task automatic access(input logic is_wr, input logic rs, input logic bs,
                          input logic [15:0] d, output logic [15:0] q,
                          output logic [15:0] oe);
        @(negedge clk);
        sel_n = 1'b0;
        reg_sel = rs;
        byte_sel = bs;
        if (is_wr) begin
            data_in = d;
        end
        @(negedge clk);
        if (is_wr) begin
            wr_n = 1'b0;
        end else begin
            rd_n = 1'b0;
        end
        repeat (6) @(negedge clk);
        q = wire_val;
        oe = data_oe;
        wr_n = 1'b1;
        rd_n = 1'b1;
        repeat (4) @(negedge clk);
        sel_n = 1'b1;
        // Released lines no longer show the last value
        data_in = ~data_in;
        repeat (6) @(negedge clk);
    endtask

    task automatic rd(input logic rs, input logic bs, output logic [15:0] q,
                      output logic [15:0] oe);
        access(1'b0, rs, bs, 16'h0000, q, oe);
    endtask

    // Writes only ever target the data register
    task automatic wr(input logic bs, input logic [15:0] d);
        logic [15:0] q;
        logic [15:0] oe;
        access(1'b1, 1'b0, bs, d, q, oe);
    endtask
endmodule

// ### tb_dsp_host_parallel_port.sv
`timescale 1ns/1ns
module tb_dsp_host_parallel_port;
    localparam logic [15:0] DT = hpp_pkg::ADDR_TRANSFER;
    localparam logic [15:0] ST = hpp_pkg::ADDR_STATUS;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] core_addr = 16'h0000;
    logic core_store = 1'b0;
    logic core_load = 1'b0;
    logic [15:0] core_wdata = 16'h0000;
    logic [15:0] core_rdata;
    logic sel_n, rd_n, wr_n, reg_sel, byte_sel;
    logic [15:0] pin_in, pin_out, pin_oe, q, oe;
    logic rdy_rd_n, rdy_wr_n, out_irq, in_irq;
    logic out_en = 1'b1;
    logic in_en = 1'b1;
    logic gate = 1'b0;
    logic out_ack = 1'b0;
    logic in_ack = 1'b0;
    logic ce = 1'b1;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    dsp_host_parallel_port u_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .core_addr(core_addr),
        .core_store(core_store), .core_load(core_load), .core_wdata(core_wdata),
        .core_rdata(core_rdata), .port_select_n(sel_n), .port_read_strobe_n(rd_n),
        .port_write_strobe_n(wr_n), .register_select_line(reg_sel),
        .byte_select_line(byte_sel), .port_data_in(pin_in), .port_data_out(pin_out),
        .port_data_oe(pin_oe), .read_ready_pin_n(rdy_rd_n), .write_ready_pin_n(rdy_wr_n),
        .out_int_enable(out_en), .in_int_enable(in_en), .global_interrupt_gate(gate),
        .out_int_ack(out_ack), .in_int_ack(in_ack),
        .outbound_done_interrupt(out_irq), .inbound_done_interrupt(in_irq)
    );

    host_cpu_model u_host (
        .clk(clk), .data_out(pin_out), .data_oe(pin_oe), .sel_n(sel_n), .rd_n(rd_n),
        .wr_n(wr_n), .reg_sel(reg_sel), .byte_sel(byte_sel), .data_in(pin_in)
    );

    // ----------------------------------------
    // Compare and bus tasks
    // ----------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic core_op(input logic st, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        core_addr = a;
        core_wdata = d;
        core_store = st;
        core_load = !st;
        @(negedge clk);
        core_store = 1'b0;
        core_load = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic ld_chk(input logic [15:0] a, input logic [15:0] exp);
        core_op(1'b0, a, 16'h0000);
        chk16(core_rdata, exp);
    endtask

    task automatic ack(input logic outbound);
        @(negedge clk);
        out_ack = outbound;
        in_ack = !outbound;
        @(negedge clk);
        out_ack = 1'b0;
        in_ack = 1'b0;
        @(negedge clk);
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk1(rdy_rd_n, 1'b1);
        chk1(rdy_wr_n, 1'b1);
        ld_chk(ST, 16'h0301);
        u_host.rd(1'b1, 1'b0, q, oe);
        chk16({8'h00, q[7:0]}, 16'h0001);
        chk16(oe, 16'h00FF);
        u_host.rd(1'b1, 1'b1, q, oe);
        chk16({8'h00, q[7:0]}, 16'h0003);
        chk16(pin_oe, 16'h0000);
        core_op(1'b1, ST, 16'h0800);
        ld_chk(ST, 16'h0801);
        core_op(1'b1, DT, 16'hA5C3);
        chk1(rdy_rd_n, 1'b0);
        core_op(1'b1, ST, 16'h0800);
        ld_chk(ST, 16'h0803);
        u_host.rd(1'b1, 1'b0, q, oe);
        chk16(q, 16'h0803);
        u_host.rd(1'b0, 1'b0, q, oe);
        chk16(q, 16'hA5C3);
        chk16(oe, 16'hFFFF);
        chk1(rdy_rd_n, 1'b1);
        chk1(out_irq, 1'b1);
        ld_chk(ST, 16'h0801);
        gate = 1'b1;
        @(negedge clk);
        chk1(out_irq, 1'b0);
        gate = 1'b0;
        out_en = 1'b0;
        @(negedge clk);
        chk1(out_irq, 1'b0);
        out_en = 1'b1;
        @(negedge clk);
        chk1(out_irq, 1'b1);
        ack(1'b1);
        chk1(out_irq, 1'b0);
        u_host.rd(1'b0, 1'b0, q, oe);
        ld_chk(ST, 16'h0821);
        ack(1'b1);
        core_op(1'b1, DT, 16'h1111);
        core_op(1'b1, DT, 16'h2222);
        ld_chk(ST, 16'h082B);
        u_host.rd(1'b0, 1'b0, q, oe);
        chk16(q, 16'h2222);
        ack(1'b1);
        core_op(1'b1, ST, 16'h083C);
        u_host.rd(1'b1, 1'b0, q, oe);
        ld_chk(ST, 16'h0829);
        core_op(1'b1, ST, 16'h0800);
        ld_chk(ST, 16'h0801);
        ce = 1'b0;
        core_op(1'b1, DT, 16'h7777);
        ce = 1'b1;
        ld_chk(ST, 16'h0801);
        u_host.wr(1'b0, 16'h1234);
        chk1(rdy_wr_n, 1'b1);
        chk1(in_irq, 1'b1);
        ld_chk(ST, 16'h0800);
        ack(1'b0);
        chk1(in_irq, 1'b0);
        u_host.wr(1'b0, 16'h5678);
        ld_chk(ST, 16'h0810);
        ld_chk(DT, 16'h1234);
        core_op(1'b0, ST, 16'h0000);
        chk16(core_rdata & 16'h0014, 16'h0014);
        ld_chk(DT, 16'h5678);
        ack(1'b0);
        core_op(1'b1, ST, 16'h0000);
        core_op(1'b1, DT, 16'hBEEF);
        u_host.rd(1'b0, 1'b0, q, oe);
        chk16({8'h00, q[7:0]}, 16'h00EF);
        chk1(rdy_rd_n, 1'b0);
        u_host.rd(1'b0, 1'b1, q, oe);
        chk16({8'h00, q[7:0]}, 16'h00BE);
        chk1(rdy_rd_n, 1'b1);
        u_host.wr(1'b0, 16'h0034);
        u_host.wr(1'b1, 16'h0012);
        ld_chk(DT, 16'h1234);
        chk1(rdy_wr_n, 1'b0);
        core_op(1'b1, DT, 16'h0055);
        chk1(rdy_rd_n, 1'b0);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk1(rdy_rd_n, 1'b1);
        chk1(rdy_wr_n, 1'b1);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        ld_chk(ST, 16'h0301);
        final_report();
    end
endmodule
